//--- rtl/mbx_pkg.sv
// Constants shared by the mailbox device, its host-side master and the bus.
// Assumes an 8-bit CPU I/O port and a 10-bit host I/O address.
package mbx_pkg;
	// CPU offsets, low address byte
	localparam logic [7:0] OFS_DMA_0 = 8'hD0;
	localparam logic [7:0] OFS_DMA_1 = 8'hD1;
	localparam logic [7:0] OFS_CTRL = 8'hD2;
	localparam logic [7:0] OFS_HOUT0 = 8'hD3;
	localparam logic [7:0] OFS_HIO1 = 8'hD4;
	localparam logic [7:0] OFS_STATUS = 8'hD5;
	// Control register fields
	localparam int CTL_WE1 = 7;
	localparam int CTL_WE0 = 6;
	localparam int CTL_REQ1 = 5;
	localparam int CTL_REQ0 = 4;
	localparam int CTL_MUX1 = 3;
	localparam int CTL_MUX0 = 2;
	localparam int CTL_EN1 = 1;
	localparam int CTL_EN0 = 0;
	// Status register fields
	localparam int STS_MBX_EN = 7;
	localparam int STS_AUX_HI = 6;
	localparam int STS_AUX_LO = 4;
	localparam int STS_IN1_AVAIL = 3;
	localparam int STS_OUT0_AVAIL = 1;
	// Host register select, address bits 1:0
	localparam logic [1:0] SEL_OUT0 = 2'h0;
	localparam logic [1:0] SEL_IO1 = 2'h1;
	localparam logic [1:0] SEL_STATUS = 2'h2;
	localparam logic [1:0] SEL_TX1 = 2'h3;
	// Reset values and the idle bus value
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BUS_IDLE = 8'hFF;
	localparam logic [3:0] CTL_LOW_RESET = 4'h0;
	// Host cycle timing, strobe low length in clocks
	localparam logic [7:0] HOST_STROBE_CYCLES = 8'h04;
endpackage

//--- rtl/mbx_host_if.sv
// Host I/O bus between the mailbox device and the host-side master.
// Resolves the shared data bus and the tristate request pins by enables.
`timescale 1ns/10ps
interface mbx_host_if;
	logic host_read_strobe_n; // Read strobe, low active
	logic host_write_strobe_n; // Write strobe, low active
	logic host_addr_enable_n; // Address enable, low for I/O cycles
	logic [7:0] host_addr_upper; // Address bits 9:2
	logic [1:0] host_addr_low; // Address bits 1:0
	logic [7:0] host_wdata; // Host data drive
	logic host_wdata_oe; // Host drives data
	logic [7:0] dev_rdata; // Device data drive
	logic dev_rdata_oe; // Device drives data
	logic [7:0] host_data; // Resolved data bus
	logic host_dma_req_pin_ch0; // Request pin drive
	logic host_dma_req_oe_ch0; // Request pin enable
	logic host_dma_req_pin_ch1;
	logic host_dma_req_oe_ch1;
	logic host_dma_req_level_ch0; // Resolved, pulled low when floating
	logic host_dma_req_level_ch1;
	logic host_dma_ack_n_ch0; // Acknowledge, low active
	logic host_dma_ack_n_ch1;
	logic host_buffer_disable_n; // Data buffer disable, low active

	// Device wins a clash; floating bus reads as pulled up
	assign host_data = dev_rdata_oe ? dev_rdata :
		(host_wdata_oe ? host_wdata : mbx_pkg::BUS_IDLE);
	assign host_dma_req_level_ch0 = host_dma_req_oe_ch0 & host_dma_req_pin_ch0;
	assign host_dma_req_level_ch1 = host_dma_req_oe_ch1 & host_dma_req_pin_ch1;

	modport device (
		input host_read_strobe_n, host_write_strobe_n, host_addr_enable_n,
		input host_addr_upper, host_addr_low, host_data,
		input host_dma_ack_n_ch0, host_dma_ack_n_ch1,
		output dev_rdata, dev_rdata_oe, host_buffer_disable_n,
		output host_dma_req_pin_ch0, host_dma_req_oe_ch0,
		output host_dma_req_pin_ch1, host_dma_req_oe_ch1
	);
	modport host (
		output host_read_strobe_n, host_write_strobe_n, host_addr_enable_n,
		output host_addr_upper, host_addr_low, host_wdata, host_wdata_oe,
		output host_dma_ack_n_ch0, host_dma_ack_n_ch1,
		input host_data, host_buffer_disable_n,
		input host_dma_req_level_ch0, host_dma_req_level_ch1
	);
endinterface

//--- rtl/host_dma_io_mailbox.sv
// Device end: two host DMA mailbox channels and the host I/O mailbox.
// Assumes host pins synchronous to clk and a CPU port with read data
// one cycle after the read strobe.
`timescale 1ns/10ps
// Function
// - CPU sets request; reset, write, strobe end clear
// - Request pin high when request and enable
// - Request pin low on reset, acknowledge, idle
// - DMA write latches host byte into transmit
// - DMA read drives receive byte onto bus
// - Buffer disable low during DMA read
// - Bit 7 gates channel-1 request write
// - Bit 6 gates channel-0 request write
// - Bit 7 reads set until first transmit-1 read
// - Bit 6 flags revision until transmit-0 read
// - Bit 3 muxes channel-1 pins to bus functions
// - Bit 2 muxes channel-0 pins to serial functions
// - Channel-1 enable; off floats pin, aux mailbox
// - Channel-0 enable; off floats request pin
// - Transmit and receive share offsets by direction
// - Mailbox hit: strobe, enable low, address match
// - Address bits 1:0 select host register
// - Address 11 writes transmit-1 when channel-1 off
// - Mailbox enable gates host and CPU accesses
// - Status bits 6-4 are CPU scratch bits
// - Input-1 flag: CPU write sets, host read clears
// - Output-0 flag: host write sets, CPU read clears
// - Software loads match address before enabling
module host_dma_io_mailbox #(
	parameter logic [7:0] REVISION_CODE = 8'h5A // Arbitrary value
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// CPU register port
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	// Mailbox match address from port A
	input wire logic [7:0] port_a_data_reg,
	// Functions sharing the channel pins
	input wire logic serial0_rts_n,
	input wire logic bus_grant_ack_n,
	output logic serial0_clock,
	output logic local_dma_req0_n,
	output logic bus_hold_req_n,
	// Host bus
	mbx_host_if.device hb
);
	logic [3:0] ctrl_ff; // Control bits 3:0
	logic dma_request_bit_ch0_ff; // Channel-0 request
	logic dma_request_bit_ch1_ff; // Channel-1 request
	logic rev_avail_ff; // Revision still readable
	logic tx1_unread_ff; // Transmit-1 never read
	logic [7:0] tx0_ff, tx1_ff, rx0_ff, rx1_ff; // DMA data
	logic [7:0] out0_ff, out1_ff, in1_ff; // Host mailbox data
	logic mbx_en_ff; // Mailbox enable
	logic [2:0] aux_ff; // Scratch bits
	logic in1_avail_ff, out0_avail_ff; // Data available flags
	logic rd_n_ff, wr_n_ff; // Strobes, last cycle
	logic ack0_n_ff, ack1_n_ff; // Acknowledges, last cycle
	logic in1_rd_ff; // Host was reading input 1
	logic [7:0] cpu_rdata_ff;
	logic [7:0] dev_rdata_ff;
	logic host_dma_enable_ch0, host_dma_enable_ch1; // Enabled and unmuxed
	logic ack0_n, ack1_n; // Effective acknowledges
	logic strobe_rise; // Last strobe just released
	logic dma_wr0, dma_wr1, dma_rd0, dma_rd1;
	logic mbx_hit, mbx_wr, mbx_rd;
	logic ctl_wr;
	logic [7:0] status;

	// Pin use and enables; muxed pins never act as acknowledges
	assign host_dma_enable_ch0 = ctrl_ff[mbx_pkg::CTL_EN0] &
		~ctrl_ff[mbx_pkg::CTL_MUX0];
	assign host_dma_enable_ch1 = ctrl_ff[mbx_pkg::CTL_EN1] &
		~ctrl_ff[mbx_pkg::CTL_MUX1];
	assign ack0_n = ctrl_ff[mbx_pkg::CTL_MUX0] | hb.host_dma_ack_n_ch0;
	assign ack1_n = ctrl_ff[mbx_pkg::CTL_MUX1] | hb.host_dma_ack_n_ch1;
	// Rising edge of the combined strobes
	assign strobe_rise = hb.host_read_strobe_n & hb.host_write_strobe_n &
		~(rd_n_ff & wr_n_ff);
	assign dma_wr0 = host_dma_enable_ch0 & ~ack0_n &
		~hb.host_write_strobe_n;
	assign dma_wr1 = host_dma_enable_ch1 & ~ack1_n &
		~hb.host_write_strobe_n;
	assign dma_rd0 = host_dma_enable_ch0 & ~ack0_n &
		~hb.host_read_strobe_n;
	assign dma_rd1 = host_dma_enable_ch1 & ~ack1_n &
		~hb.host_read_strobe_n;
	// Mailbox decode, dead while the mailbox is disabled
	assign mbx_hit = mbx_en_ff & ~hb.host_addr_enable_n &
		(hb.host_addr_upper == port_a_data_reg);
	assign mbx_wr = mbx_hit & ~hb.host_write_strobe_n;
	assign mbx_rd = mbx_hit & ~hb.host_read_strobe_n;
	assign ctl_wr = cpu_wr & (cpu_addr == mbx_pkg::OFS_CTRL);
	assign status = {mbx_en_ff, aux_ff, in1_avail_ff, 1'b0,
		out0_avail_ff, 1'b0};

	// Strobe and acknowledge history for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
			ack0_n_ff <= 1'b1;
			ack1_n_ff <= 1'b1;
			in1_rd_ff <= 1'b0;
		end else begin
			rd_n_ff <= hb.host_read_strobe_n;
			wr_n_ff <= hb.host_write_strobe_n;
			ack0_n_ff <= ack0_n;
			ack1_n_ff <= ack1_n;
			in1_rd_ff <= mbx_rd & (hb.host_addr_low == mbx_pkg::SEL_IO1);
		end
	end

	// Request bits; a CPU write beats the transfer-end clear
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_request_bit_ch0_ff <= 1'b0;
			dma_request_bit_ch1_ff <= 1'b0;
		end else begin
			if (ctl_wr & cpu_wdata[mbx_pkg::CTL_WE0]) begin
				dma_request_bit_ch0_ff <= cpu_wdata[mbx_pkg::CTL_REQ0];
			end else if (strobe_rise & ~ack0_n_ff) begin
				dma_request_bit_ch0_ff <= 1'b0;
			end
			if (ctl_wr & cpu_wdata[mbx_pkg::CTL_WE1]) begin
				dma_request_bit_ch1_ff <= cpu_wdata[mbx_pkg::CTL_REQ1];
			end else if (strobe_rise & ~ack1_n_ff) begin
				dma_request_bit_ch1_ff <= 1'b0;
			end
		end
	end

	// Mux and enable bits; any write-enable bit locks them out
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= mbx_pkg::CTL_LOW_RESET;
		end else if (ctl_wr & ~cpu_wdata[mbx_pkg::CTL_WE1] &
			~cpu_wdata[mbx_pkg::CTL_WE0]) begin
			ctrl_ff <= cpu_wdata[3:0];
		end
	end

	// Read-once flags, revision and first transmit-1 read
	always_ff @(posedge clk) begin
		if (rst) begin
			rev_avail_ff <= 1'b1;
			tx1_unread_ff <= 1'b1;
		end else begin
			if (cpu_rd & (cpu_addr == mbx_pkg::OFS_DMA_0)) begin
				rev_avail_ff <= 1'b0;
			end
			if (cpu_rd & (cpu_addr == mbx_pkg::OFS_DMA_1)) begin
				tx1_unread_ff <= 1'b0;
			end
		end
	end

	// Transmit registers, host side; level latch while strobe is low
	always_ff @(posedge clk) begin
		if (rst) begin
			tx0_ff <= mbx_pkg::BYTE_ZERO;
			tx1_ff <= mbx_pkg::BYTE_ZERO;
		end else begin
			if (dma_wr0) begin
				tx0_ff <= hb.host_data;
			end
			if (dma_wr1 | (mbx_wr & ~ctrl_ff[mbx_pkg::CTL_EN1] &
				(hb.host_addr_low == mbx_pkg::SEL_TX1))) begin
				tx1_ff <= hb.host_data;
			end
		end
	end

	// Receive registers and input 1, CPU side
	always_ff @(posedge clk) begin
		if (rst) begin
			rx0_ff <= mbx_pkg::BYTE_ZERO;
			rx1_ff <= mbx_pkg::BYTE_ZERO;
			in1_ff <= mbx_pkg::BYTE_ZERO;
		end else if (cpu_wr) begin
			if (cpu_addr == mbx_pkg::OFS_DMA_0) begin
				rx0_ff <= cpu_wdata;
			end
			if (cpu_addr == mbx_pkg::OFS_DMA_1) begin
				rx1_ff <= cpu_wdata;
			end
			if ((cpu_addr == mbx_pkg::OFS_HIO1) & mbx_en_ff) begin
				in1_ff <= cpu_wdata;
			end
		end
	end

	// Host output registers
	always_ff @(posedge clk) begin
		if (rst) begin
			out0_ff <= mbx_pkg::BYTE_ZERO;
			out1_ff <= mbx_pkg::BYTE_ZERO;
		end else if (mbx_wr) begin
			if (hb.host_addr_low == mbx_pkg::SEL_OUT0) begin
				out0_ff <= hb.host_data;
			end
			if (hb.host_addr_low == mbx_pkg::SEL_IO1) begin
				out1_ff <= hb.host_data;
			end
		end
	end

	// Enable and scratch bits; only bit 7 is writable while disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			mbx_en_ff <= 1'b0;
			aux_ff <= 3'h0;
		end else if (cpu_wr & (cpu_addr == mbx_pkg::OFS_STATUS)) begin
			mbx_en_ff <= cpu_wdata[mbx_pkg::STS_MBX_EN];
			if (mbx_en_ff) begin
				aux_ff <= cpu_wdata[mbx_pkg::STS_AUX_HI:mbx_pkg::STS_AUX_LO];
			end
		end
	end

	// Data available flags; set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			in1_avail_ff <= 1'b0;
			out0_avail_ff <= 1'b0;
		end else begin
			if (cpu_wr & (cpu_addr == mbx_pkg::OFS_HIO1) & mbx_en_ff) begin
				in1_avail_ff <= 1'b1;
			end else if (in1_rd_ff & ~(mbx_rd &
				(hb.host_addr_low == mbx_pkg::SEL_IO1))) begin
				in1_avail_ff <= 1'b0;
			end
			if (mbx_wr & (hb.host_addr_low == mbx_pkg::SEL_OUT0)) begin
				out0_avail_ff <= 1'b1;
			end else if (cpu_rd & (cpu_addr == mbx_pkg::OFS_HOUT0) &
				mbx_en_ff) begin
				out0_avail_ff <= 1'b0;
			end
		end
	end

	// CPU read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_rdata_ff <= mbx_pkg::BYTE_ZERO;
		end else if (cpu_rd) begin
			case (cpu_addr)
				mbx_pkg::OFS_DMA_0: cpu_rdata_ff <= rev_avail_ff ?
					REVISION_CODE : tx0_ff;
				mbx_pkg::OFS_DMA_1: cpu_rdata_ff <= tx1_ff;
				mbx_pkg::OFS_CTRL: cpu_rdata_ff <= {tx1_unread_ff, rev_avail_ff,
					dma_request_bit_ch1_ff, dma_request_bit_ch0_ff,
					ctrl_ff};
				mbx_pkg::OFS_HOUT0: cpu_rdata_ff <= mbx_en_ff ?
					out0_ff : mbx_pkg::BYTE_ZERO;
				mbx_pkg::OFS_HIO1: cpu_rdata_ff <= mbx_en_ff ?
					out1_ff : mbx_pkg::BYTE_ZERO;
				mbx_pkg::OFS_STATUS: cpu_rdata_ff <= mbx_en_ff ?
					status : mbx_pkg::BYTE_ZERO;
				default: cpu_rdata_ff <= mbx_pkg::BYTE_ZERO;
			endcase
		end else begin
			cpu_rdata_ff <= mbx_pkg::BYTE_ZERO;
		end
	end

	// Host read data, registered; valid from the second strobe cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			dev_rdata_ff <= mbx_pkg::BYTE_ZERO;
		end else if (dma_rd0) begin
			dev_rdata_ff <= rx0_ff;
		end else if (dma_rd1) begin
			dev_rdata_ff <= rx1_ff;
		end else begin
			case (hb.host_addr_low)
				mbx_pkg::SEL_OUT0: dev_rdata_ff <= out0_ff;
				mbx_pkg::SEL_IO1: dev_rdata_ff <= in1_ff;
				mbx_pkg::SEL_STATUS: dev_rdata_ff <= status;
				default: dev_rdata_ff <= mbx_pkg::BYTE_ZERO;
			endcase
		end
	end

	// Host bus drive; address 11 is write-only, so never driven
	assign hb.dev_rdata = dev_rdata_ff;
	assign hb.dev_rdata_oe = dma_rd0 | dma_rd1 | (mbx_rd &
		(hb.host_addr_low != mbx_pkg::SEL_TX1));
	assign hb.host_buffer_disable_n = ~(~hb.host_read_strobe_n &
		(~ack0_n | ~ack1_n));
	assign cpu_rdata = cpu_rdata_ff;

	// Request pins or their shared functions
	assign hb.host_dma_req_pin_ch0 = ctrl_ff[mbx_pkg::CTL_MUX0] ? serial0_rts_n :
		(dma_request_bit_ch0_ff & ack0_n);
	assign hb.host_dma_req_oe_ch0 = ctrl_ff[mbx_pkg::CTL_MUX0] |
		ctrl_ff[mbx_pkg::CTL_EN0];
	assign hb.host_dma_req_pin_ch1 = ctrl_ff[mbx_pkg::CTL_MUX1] ?
		bus_grant_ack_n : (dma_request_bit_ch1_ff & ack1_n);
	assign hb.host_dma_req_oe_ch1 = ctrl_ff[mbx_pkg::CTL_MUX1] |
		ctrl_ff[mbx_pkg::CTL_EN1];
	// Acknowledge pins as serial clock, DMA request or bus request
	assign serial0_clock = ctrl_ff[mbx_pkg::CTL_MUX0] & hb.host_dma_ack_n_ch0;
	assign local_dma_req0_n = ~ctrl_ff[mbx_pkg::CTL_MUX0] |
		hb.host_dma_ack_n_ch0;
	assign bus_hold_req_n = ~ctrl_ff[mbx_pkg::CTL_MUX1] |
		hb.host_dma_ack_n_ch1;
endmodule

//--- rtl/host_dma_io_master.sv
// Host end: answers DMA requests and runs single I/O cycles on command.
// Assumes the device answers read data by the second strobe-low cycle.
`timescale 1ns/10ps
module host_dma_io_master #(
	parameter logic [7:0] STROBE_CYCLES = mbx_pkg::HOST_STROBE_CYCLES
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// I/O command
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [9:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	// DMA channel setup
	input wire logic dma_en_ch0,
	input wire logic dma_en_ch1,
	input wire logic dma_write_ch0,
	input wire logic dma_write_ch1,
	input wire logic [7:0] dma_wdata,
	// Response
	output logic rsp_valid,
	output logic rsp_dma,
	output logic rsp_ch,
	output logic [7:0] rsp_data,
	// Host bus
	mbx_host_if.host hb
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE
	} cyc_state_e;

	cyc_state_e state_ff, nxt_state;
	logic is_dma_ff, ch_ff, is_write_ff; // Current cycle kind
	logic [9:0] addr_ff;
	logic [7:0] wdata_ff;
	logic [7:0] cnt_ff; // Strobe cycles left
	logic rsp_valid_ff, rsp_dma_ff, rsp_ch_ff;
	logic [7:0] rsp_data_ff;
	logic req0, req1; // Serviceable requests
	logic active; // Between setup and hold

	assign req0 = dma_en_ch0 & hb.host_dma_req_level_ch0;
	assign req1 = dma_en_ch1 & hb.host_dma_req_level_ch1;
	assign active = (state_ff == ST_SETUP) | (state_ff == ST_STROBE) |
		(state_ff == ST_HOLD);

	// Cycle sequencer; the hold cycle lets the device see strobe release
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: if (req0 | req1 | cmd_valid) begin
				nxt_state = ST_SETUP;
			end
			ST_SETUP: nxt_state = ST_STROBE;
			ST_STROBE: if (cnt_ff == 8'h00) begin
				nxt_state = ST_HOLD;
			end
			ST_HOLD: nxt_state = ST_DONE;
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Cycle capture; channel 0 beats channel 1 beats commands
	always_ff @(posedge clk) begin
		if (rst) begin
			is_dma_ff <= 1'b0;
			ch_ff <= 1'b0;
			is_write_ff <= 1'b0;
			addr_ff <= 10'h000;
			wdata_ff <= mbx_pkg::BYTE_ZERO;
		end else if (state_ff == ST_IDLE) begin
			is_dma_ff <= req0 | req1;
			ch_ff <= ~req0 & req1;
			if (req0) begin
				is_write_ff <= dma_write_ch0;
				wdata_ff <= dma_wdata;
			end else if (req1) begin
				is_write_ff <= dma_write_ch1;
				wdata_ff <= dma_wdata;
			end else begin
				is_write_ff <= cmd_write;
				wdata_ff <= cmd_wdata;
				addr_ff <= cmd_addr;
			end
		end
	end

	// Strobe length counter
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 8'h00;
		end else if (state_ff == ST_SETUP) begin
			cnt_ff <= STROBE_CYCLES - 8'h01;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end

	// Response; read data taken in the last strobe cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_dma_ff <= 1'b0;
			rsp_ch_ff <= 1'b0;
			rsp_data_ff <= mbx_pkg::BYTE_ZERO;
		end else begin
			rsp_valid_ff <= state_ff == ST_HOLD;
			if ((state_ff == ST_STROBE) & (cnt_ff == 8'h00)) begin
				rsp_dma_ff <= is_dma_ff;
				rsp_ch_ff <= ch_ff;
				rsp_data_ff <= is_write_ff ? wdata_ff : hb.host_data;
			end
		end
	end

	// Bus pins; address enable high marks a DMA cycle
	assign hb.host_addr_enable_n = ~(active & ~is_dma_ff);
	assign hb.host_addr_upper = addr_ff[9:2];
	assign hb.host_addr_low = addr_ff[1:0];
	assign hb.host_read_strobe_n = ~((state_ff == ST_STROBE) & ~is_write_ff);
	assign hb.host_write_strobe_n = ~((state_ff == ST_STROBE) & is_write_ff);
	assign hb.host_wdata = wdata_ff;
	assign hb.host_wdata_oe = active & is_write_ff;
	assign hb.host_dma_ack_n_ch0 = ~(active & is_dma_ff & ~ch_ff);
	assign hb.host_dma_ack_n_ch1 = ~(active & is_dma_ff & ch_ff);
	assign cmd_ready = (state_ff == ST_IDLE) & ~req0 & ~req1;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_dma = rsp_dma_ff;
	assign rsp_ch = rsp_ch_ff;
	assign rsp_data = rsp_data_ff;
endmodule

//--- verif/mbx_sva.sv
// Checker for the host bus that joins the mailbox device and host master.
// Sees only interface signals; the bench instantiates it beside the bus.
`timescale 1ns/10ps
module mbx_sva (
	// System
	input wire logic clk,
	input wire logic rst,
	// Host strobes and address
	input wire logic host_read_strobe_n,
	input wire logic host_write_strobe_n,
	input wire logic [1:0] host_addr_low,
	// DMA pins
	input wire logic host_dma_ack_n_ch0,
	input wire logic host_dma_ack_n_ch1,
	input wire logic host_dma_req_oe_ch0,
	input wire logic host_dma_req_level_ch0,
	input wire logic host_dma_req_level_ch1,
	// Device drive
	input wire logic dev_rdata_oe,
	input wire logic host_buffer_disable_n
);
	// One domain only
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Any acknowledge low, muxed channels keep theirs high
	wire logic any_ack = !host_dma_ack_n_ch0 || !host_dma_ack_n_ch1;
	property p_ack0_low;
		!host_dma_ack_n_ch0 |-> !host_dma_req_level_ch0;
	endproperty
	a_ack0_low: assert property (p_ack0_low)
		else $error("request 0 high during acknowledge");
	property p_ack1_low;
		!host_dma_ack_n_ch1 |-> !host_dma_req_level_ch1;
	endproperty
	a_ack1_low: assert property (p_ack1_low)
		else $error("request 1 high during acknowledge");
	property p_done0;
		$rose(host_dma_ack_n_ch0) |-> !host_dma_req_level_ch0[*2];
	endproperty
	a_done0: assert property (p_done0)
		else $error("request 0 not cleared after transfer");
	property p_done1;
		$rose(host_dma_ack_n_ch1) |-> !host_dma_req_level_ch1[*2];
	endproperty
	a_done1: assert property (p_done1)
		else $error("request 1 not cleared after transfer");
	property p_dma_rd;
		!host_dma_ack_n_ch0 && host_dma_req_oe_ch0 && !host_read_strobe_n
			|-> dev_rdata_oe;
	endproperty
	a_dma_rd: assert property (p_dma_rd)
		else $error("receive byte not driven in DMA read");
	property p_buf_on;
		any_ack && !host_read_strobe_n |-> !host_buffer_disable_n;
	endproperty
	a_buf_on: assert property (p_buf_on)
		else $error("buffer disable high in DMA read");
	property p_buf_off;
		!host_buffer_disable_n |-> any_ack && !host_read_strobe_n;
	endproperty
	a_buf_off: assert property (p_buf_off)
		else $error("buffer disable low outside DMA read");
	property p_drive_rd;
		dev_rdata_oe |-> !host_read_strobe_n && host_write_strobe_n;
	endproperty
	a_drive_rd: assert property (p_drive_rd)
		else $error("device drives data outside a read");
	property p_tx1_rd;
		!host_read_strobe_n && !any_ack && host_addr_low == 2'h3
			|-> !dev_rdata_oe;
	endproperty
	a_tx1_rd: assert property (p_tx1_rd)
		else $error("device drives data on address 11 read");
	// Main scenarios
	c_dma_wr: cover property (!host_dma_ack_n_ch1 && !host_write_strobe_n);
	c_dma_rd: cover property (!host_dma_ack_n_ch0 && !host_read_strobe_n);
	c_mbx_rd: cover property (!any_ack && dev_rdata_oe);
endmodule

//--- verif/tb.sv
// Bench: mailbox device and host master joined over the host bus.
// Drives the CPU port and the master's command port; one clock.
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary value
	logic clk, rst, cpu_wr, cpu_rd, cmd_valid, cmd_write, cmd_ready;
	logic rts_n, grant_n, dma_en0, dma_en1, rsp_valid, rsp_dma, rsp_ch;
	logic rd_d = 1'b0; // Read taken last edge
	logic sclk, dreq_n, hold_n; // Shared pin functions
	logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, port_a, dma_wdata;
	logic [7:0] cmd_wdata, rsp_data, seed, d, pa;
	logic [9:0] cmd_addr;
	logic [9:0] q_cpu[$], q_rsp[$]; // Expected results, oldest first
	int bad_count, n_compared, n_rsp, cyc;
	mbx_host_if hb ();
	host_dma_io_mailbox #(.REVISION_CODE(REV)) i_host_dma_io_mailbox (
		.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.port_a_data_reg(port_a), .serial0_rts_n(rts_n),
		.bus_grant_ack_n(grant_n), .serial0_clock(sclk),
		.local_dma_req0_n(dreq_n), .bus_hold_req_n(hold_n),
		.hb(hb.device));
	// Short strobes keep the run brief
	host_dma_io_master #(.STROBE_CYCLES(8'h02)) i_host_dma_io_master (
		.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.dma_en_ch0(dma_en0), .dma_en_ch1(dma_en1), .dma_write_ch0(1'b0),
		.dma_write_ch1(1'b1), .dma_wdata(dma_wdata), .rsp_valid(rsp_valid),
		.rsp_dma(rsp_dma), .rsp_ch(rsp_ch), .rsp_data(rsp_data),
		.hb(hb.host));
	mbx_sva i_mbx_sva (.clk(clk), .rst(rst),
		.host_read_strobe_n(hb.host_read_strobe_n),
		.host_write_strobe_n(hb.host_write_strobe_n),
		.host_addr_low(hb.host_addr_low),
		.host_dma_ack_n_ch0(hb.host_dma_ack_n_ch0),
		.host_dma_ack_n_ch1(hb.host_dma_ack_n_ch1),
		.host_dma_req_oe_ch0(hb.host_dma_req_oe_ch0),
		.host_dma_req_level_ch0(hb.host_dma_req_level_ch0),
		.host_dma_req_level_ch1(hb.host_dma_req_level_ch1),
		.dev_rdata_oe(hb.dev_rdata_oe),
		.host_buffer_disable_n(hb.host_buffer_disable_n));
	// Clock, 20 ns
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string n, input logic [9:0] e, g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		// Unanswered notes count as misses
		bad_count += q_cpu.size() + q_rsp.size();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// CPU write; idle edge after so strobes never merge
	task automatic cw(input logic [7:0] a, v);
		cpu_addr <= a;
		cpu_wdata <= v;
		cpu_wr <= 1'b1;
		@(posedge clk);
		cpu_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cr(input logic [7:0] a, e);
		q_cpu.push_back({2'h0, e});
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge clk);
		cpu_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_rsp;
		int k;
		k = n_rsp;
		repeat (40) if (n_rsp == k) @(posedge clk);
	endtask
	// One host I/O cycle; request held until taken
	task automatic hio(input logic w, input logic [9:0] a,
		input logic [7:0] v, e);
		q_rsp.push_back({2'h0, e});
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= v;
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		wait_rsp();
	endtask
	// Result watcher; channel only means something for DMA
	always @(posedge clk) begin
		if (rd_d) chk("cpu_rdata", q_cpu.pop_front(), {2'h0, cpu_rdata});
		if (rsp_valid === 1'b1) begin
			chk("rsp", q_rsp.pop_front(), {rsp_dma, rsp_dma & rsp_ch,
				rsp_data});
			n_rsp <= n_rsp + 1;
		end
		rd_d <= cpu_rd;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		{rst, rts_n} = 2'h3;
		{cpu_wr, cpu_rd, cmd_valid, cmd_write, grant_n, dma_en0} = 6'h00;
		{dma_en1, cpu_addr, cpu_wdata, port_a, dma_wdata} = 33'h0;
		{cmd_addr, cmd_wdata} = 18'h0;
		{bad_count, n_compared, n_rsp, cyc} = '0;
		seed = 8'h4C;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cr(mbx_pkg::OFS_CTRL, 8'hC0);
		cr(mbx_pkg::OFS_DMA_0, REV);
		cr(mbx_pkg::OFS_CTRL, 8'h80);
		cr(mbx_pkg::OFS_DMA_1, 8'h00);
		cr(mbx_pkg::OFS_CTRL, 8'h00);
		cr(mbx_pkg::OFS_HOUT0, 8'h00);
		cr(8'hE0, 8'h00);
		cw(mbx_pkg::OFS_CTRL, 8'h0C);
		chk("mux", 10'h002, {8'h0, hb.host_dma_req_level_ch0,
			hb.host_dma_req_level_ch1});
		// Idle acknowledges pass through to the shared functions
		chk("pins", 10'h007, {7'h0, sclk, dreq_n, hold_n});
		$display("test reset and mux done");
		cw(mbx_pkg::OFS_CTRL, 8'h02);
		seed = lfsr(seed);
		d = seed;
		{dma_wdata, dma_en0, dma_en1} <= {d, 2'h3};
		q_rsp.push_back({2'h3, d});
		cw(mbx_pkg::OFS_CTRL, 8'hA0);
		wait_rsp();
		cr(mbx_pkg::OFS_CTRL, 8'h02);
		cr(mbx_pkg::OFS_DMA_1, d);
		seed = lfsr(seed);
		d = seed;
		cw(mbx_pkg::OFS_DMA_0, d);
		cw(mbx_pkg::OFS_CTRL, 8'h01);
		q_rsp.push_back({2'h2, d});
		cw(mbx_pkg::OFS_CTRL, 8'h50);
		wait_rsp();
		cr(mbx_pkg::OFS_CTRL, 8'h01);
		cw(mbx_pkg::OFS_CTRL, 8'h00);
		$display("test dma done");
		seed = lfsr(seed);
		pa = seed;
		port_a <= pa;
		hio(1'b0, {pa, mbx_pkg::SEL_STATUS}, 8'h00, 8'hFF);
		cw(mbx_pkg::OFS_STATUS, 8'hF5);
		cr(mbx_pkg::OFS_STATUS, 8'h80);
		cw(mbx_pkg::OFS_STATUS, 8'hF5);
		cr(mbx_pkg::OFS_STATUS, 8'hF0);
		seed = lfsr(seed);
		d = seed;
		hio(1'b1, {pa, mbx_pkg::SEL_OUT0}, d, d);
		cr(mbx_pkg::OFS_STATUS, 8'hF2);
		cr(mbx_pkg::OFS_HOUT0, d);
		hio(1'b1, {~pa, mbx_pkg::SEL_OUT0}, d, d);
		cr(mbx_pkg::OFS_STATUS, 8'hF0);
		cw(mbx_pkg::OFS_HIO1, d);
		cr(mbx_pkg::OFS_STATUS, 8'hF8);
		hio(1'b0, {pa, mbx_pkg::SEL_IO1}, 8'h00, d);
		hio(1'b0, {pa, mbx_pkg::SEL_STATUS}, 8'h00, 8'hF0);
		seed = lfsr(seed);
		d = seed;
		hio(1'b1, {pa, mbx_pkg::SEL_TX1}, d, d);
		cr(mbx_pkg::OFS_DMA_1, d);
		hio(1'b0, {pa, mbx_pkg::SEL_TX1}, 8'h00, 8'hFF);
		$display("test mailbox done");
		wrap_up();
	end
endmodule
